/* core/hlie_regs.svh */
// Purpose: Offsets, field positions, reset values of the link IRQ block
// Assumes: Avalon-MM word addressing, one 32-bit word per register
// Notes: Included by the top module and the testbench only
`ifndef HLIE_REGS_SVH
`define HLIE_REGS_SVH
`define HLIE_ADDR_W 4
`define HLIE_OFF_STATUS 4'h0
`define HLIE_OFF_ENABLE 4'h1
`define HLIE_OFF_MASK 4'h2
`define HLIE_OFF_RAWST 4'h3
`define HLIE_BIT_TX_BEGIN 6
`define HLIE_BIT_RX_BEGIN 5
`define HLIE_BIT_TX_FINISH 4
`define HLIE_BIT_RX_FINISH 3
`define HLIE_EV_LO 3
`define HLIE_EV_HI 6
`define HLIE_IMPL_MASK 8'h78
`define HLIE_ENABLE_RST 8'h00
`define HLIE_MASK_RST 8'h78
`define HLIE_UNMAPPED_DATA 32'hDEADBEEF
`endif

/* core/hlie_pkg.sv */
// Purpose: Types of the link IRQ block
// Assumes: Nothing
// Notes: Constants live in hlie_regs.svh
package hlie_pkg;
  typedef logic [7:0] hlie_byte_t;
  typedef logic [3:0] hlie_ev_t;
  typedef enum logic [2:0]
  {
    HLIE_IDLE = 3'b001,
    HLIE_ACK = 3'b010,
    HLIE_HOLD = 3'b100
  } hlie_bus_st_t;
endpackage

/* core/hlie_sync.sv */
// Purpose: Two-flop synchroniser and rise detector per event line
// Assumes: Event lines come from another clock or pin
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
module hlie_sync
  import hlie_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire hlie_pkg::hlie_ev_t ev_i,
  output hlie_pkg::hlie_ev_t pulse_o
);
  typedef struct packed
  {
    hlie_ev_t s1;
    hlie_ev_t s2;
    hlie_ev_t s3;
  } hlie_sync_st_t;
  hlie_sync_st_t st_r;
  hlie_sync_st_t st_nxt;
  always_comb
  begin
    st_nxt = st_r;
    if (ce_i)
    begin
      st_nxt.s1 = ev_i;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
    end
  end
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  // Rising edge only, so a held event line counts once
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_edge
      assign pulse_o[g] = ce_i & st_r.s2[g] & ~st_r.s3[g];
    end
  endgenerate
endmodule

/* core/hlie_flags.sv */
// Purpose: Sticky status flags, set wins over clear
// Assumes: One-cycle set pulses and one-cycle clear vector
// Notes: Frozen while ce_i is low
`timescale 1ns/100ps
module hlie_flags
  import hlie_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire hlie_pkg::hlie_ev_t set_i,
  input wire hlie_pkg::hlie_ev_t clr_i,
  output hlie_pkg::hlie_ev_t flag_o
);
  typedef struct packed
  {
    hlie_ev_t flag;
  } hlie_flag_st_t;
  hlie_flag_st_t st_r;
  hlie_flag_st_t st_nxt;
  always_comb
  begin
    st_nxt = st_r;
    if (ce_i)
      st_nxt.flag = (st_r.flag & ~clr_i) | set_i;
  end
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign flag_o = st_r.flag;
endmodule

/* core/hlie_top.sv */
// Purpose: Interrupt enable, status and mask for link controller pair two
// Assumes: Avalon-MM slave, word addressed, 40 MHz core_clk_i
// Notes: Status clears on read and on write of one; set beats clear
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
`include "hlie_regs.svh"
// How it works
// - Tx begin event raises interrupt when enable bit 6 is one.
// - Rx begin event raises interrupt when enable bit 5 is one.
// - Tx finish event raises interrupt when enable bit 4 is one.
// - Rx finish event raises interrupt when enable bit 3 is one.
// - Event flags stick until status read or written with one, regardless of enable bits.
module hlie_top
  import hlie_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [`HLIE_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic tx_begin_event_i,
  input wire logic rx_begin_event_i,
  input wire logic tx_finish_event_i,
  input wire logic rx_finish_event_i,
  output logic irq_o
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed
  {
    hlie_bus_st_t bus;
    hlie_byte_t enable;
    hlie_byte_t mask;
    logic [31:0] rdata;
  } hlie_top_st_t;
  hlie_top_st_t st_r;
  hlie_top_st_t st_nxt;
  hlie_ev_t ev_raw;
  hlie_ev_t ev_pulse;
  hlie_ev_t flag;
  hlie_ev_t clr;
  hlie_byte_t status_b;
  hlie_byte_t wbyte;
  logic acc;
  assign ev_raw = {tx_begin_event_i, rx_begin_event_i,
                   tx_finish_event_i, rx_finish_event_i};
  hlie_sync u_sync
  (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .ev_i(ev_raw),
    .pulse_o(ev_pulse)
  );
  hlie_flags u_flags
  (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .set_i(ev_pulse),
    .clr_i(clr),
    .flag_o(flag)
  );
  assign status_b = {1'b0, flag, 3'h0};
  assign wbyte = avs_writedata_i[7:0];
  // ****************************************
  // Bus slave
  // ****************************************
  // One wait cycle: the answer is taken in ACK, then HOLD drops it
  assign acc = ce_i && (st_r.bus == HLIE_ACK);
  // Clear only what the captured word showed, so a late event survives
  always_comb
  begin
    clr = '0;
    if (acc && avs_read_i && avs_address_i == `HLIE_OFF_STATUS)
      clr = st_r.rdata[`HLIE_EV_HI:`HLIE_EV_LO];
    else if (acc && avs_write_i && avs_byteenable_i[0] &&
             avs_address_i == `HLIE_OFF_STATUS)
      clr = wbyte[`HLIE_EV_HI:`HLIE_EV_LO];
  end
  always_comb
  begin
    st_nxt = st_r;
    if (ce_i)
    begin
      case (st_r.bus)
        HLIE_IDLE:
        begin
          if (avs_read_i || avs_write_i)
          begin
            st_nxt.bus = HLIE_ACK;
            case (avs_address_i)
              `HLIE_OFF_STATUS: st_nxt.rdata = {24'h0, status_b};
              `HLIE_OFF_ENABLE: st_nxt.rdata = {24'h0, st_r.enable};
              `HLIE_OFF_MASK: st_nxt.rdata = {24'h0, st_r.mask};
              `HLIE_OFF_RAWST:
                st_nxt.rdata = {24'h0, 1'b0, ev_pulse, 3'h0};
              default: st_nxt.rdata = `HLIE_UNMAPPED_DATA;
            endcase
          end
        end
        HLIE_ACK:
        begin
          st_nxt.bus = HLIE_HOLD;
          if (avs_write_i && avs_byteenable_i[0])
          begin
            if (avs_address_i == `HLIE_OFF_ENABLE)
              st_nxt.enable = wbyte & `HLIE_IMPL_MASK;
            if (avs_address_i == `HLIE_OFF_MASK)
              st_nxt.mask = wbyte & `HLIE_IMPL_MASK;
          end
        end
        HLIE_HOLD: st_nxt.bus = HLIE_IDLE;
        default: st_nxt.bus = HLIE_IDLE;
      endcase
    end
  end
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_r.bus <= HLIE_IDLE;
      st_r.enable <= `HLIE_ENABLE_RST;
      st_r.mask <= `HLIE_MASK_RST;
      st_r.rdata <= 32'h0;
    end
    else
      st_r <= st_nxt;
  end
  // Held high while frozen, so no answer is shown that is not taken
  assign avs_waitrequest_o = !(ce_i && (st_r.bus == HLIE_ACK));
  assign avs_readdata_o = st_r.rdata;
  // ****************************************
  // Interrupt
  // ****************************************
  // Enable and mask both gate the sticky flags onto irq_o
  hlie_ev_t gate;
  assign gate = flag & st_r.enable[`HLIE_EV_HI:`HLIE_EV_LO] &
                st_r.mask[`HLIE_EV_HI:`HLIE_EV_LO];
  assign irq_o = |gate;
  // ****************************************
  // Checks
  // ****************************************
  property p_tx_begin;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (flag[3] && st_r.enable[`HLIE_BIT_TX_BEGIN] &&
     st_r.mask[`HLIE_BIT_TX_BEGIN]) |-> irq_o;
  endproperty
  a_tx_begin: assert property (p_tx_begin)
    else $error("tx begin irq missing");
  property p_rx_begin;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (flag[2] && st_r.enable[`HLIE_BIT_RX_BEGIN] &&
     st_r.mask[`HLIE_BIT_RX_BEGIN]) |-> irq_o;
  endproperty
  a_rx_begin: assert property (p_rx_begin)
    else $error("rx begin irq missing");
  property p_tx_finish;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (flag[1] && st_r.enable[`HLIE_BIT_TX_FINISH] &&
     st_r.mask[`HLIE_BIT_TX_FINISH]) |-> irq_o;
  endproperty
  a_tx_finish: assert property (p_tx_finish)
    else $error("tx finish irq missing");
  property p_rx_finish;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (flag[0] && st_r.enable[`HLIE_BIT_RX_FINISH] &&
     st_r.mask[`HLIE_BIT_RX_FINISH]) |-> irq_o;
  endproperty
  a_rx_finish: assert property (p_rx_finish)
    else $error("rx finish irq missing");
  property p_no_irq;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (st_r.enable == 8'h00) |-> !irq_o;
  endproperty
  a_no_irq: assert property (p_no_irq)
    else $error("irq while all enables off");
  property p_sticky;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (ce_i && ev_pulse[3]) |=> flag[3];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("event flag not set");
  property p_hold;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (flag[0] && clr[0] == 1'b0) |=> flag[0];
  endproperty
  a_hold: assert property (p_hold)
    else $error("flag lost without clear");
  property p_rsvd;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (st_r.enable[7] == 1'b0) && (st_r.enable[2:0] == 3'h0);
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved enable bit set");
  property p_ack;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (ce_i && st_r.bus == HLIE_IDLE && avs_read_i) |=>
      !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("read not answered in one wait cycle");
  property p_tx_begin_off;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (flag == 4'h8 && !st_r.enable[`HLIE_BIT_TX_BEGIN]) |-> !irq_o;
  endproperty
  a_tx_begin_off: assert property (p_tx_begin_off)
    else $error("tx begin irq while disabled");
  property p_rx_begin_off;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (flag == 4'h4 && !st_r.enable[`HLIE_BIT_RX_BEGIN]) |-> !irq_o;
  endproperty
  a_rx_begin_off: assert property (p_rx_begin_off)
    else $error("rx begin irq while disabled");
  property p_tx_finish_off;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (flag == 4'h2 && !st_r.enable[`HLIE_BIT_TX_FINISH]) |-> !irq_o;
  endproperty
  a_tx_finish_off: assert property (p_tx_finish_off)
    else $error("tx finish irq while disabled");
  property p_rx_finish_off;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (flag == 4'h1 && !st_r.enable[`HLIE_BIT_RX_FINISH]) |-> !irq_o;
  endproperty
  a_rx_finish_off: assert property (p_rx_finish_off)
    else $error("rx finish irq while disabled");
  property p_sticky_rx_begin;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (ce_i && ev_pulse[2]) |=> flag[2];
  endproperty
  a_sticky_rx_begin: assert property (p_sticky_rx_begin)
    else $error("rx begin flag not set");
  property p_sticky_tx_finish;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (ce_i && ev_pulse[1]) |=> flag[1];
  endproperty
  a_sticky_tx_finish: assert property (p_sticky_tx_finish)
    else $error("tx finish flag not set");
  property p_sticky_rx_finish;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (ce_i && ev_pulse[0]) |=> flag[0];
  endproperty
  a_sticky_rx_finish: assert property (p_sticky_rx_finish)
    else $error("rx finish flag not set");
  property p_read_clear;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (acc && avs_read_i && avs_address_i == `HLIE_OFF_STATUS &&
     st_r.rdata[`HLIE_BIT_RX_FINISH] && !ev_pulse[0]) |=> !flag[0];
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("status read did not clear flag");
  property p_enable_write;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (acc && avs_write_i && avs_byteenable_i[0] &&
     avs_address_i == `HLIE_OFF_ENABLE) |=>
      (st_r.enable == ($past(wbyte) & `HLIE_IMPL_MASK));
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable write not taken");
  property p_enable_keep;
    @(posedge core_clk_i) disable iff (!nrst_i)
    !(acc && avs_write_i && avs_byteenable_i[0] &&
      avs_address_i == `HLIE_OFF_ENABLE) |=> $stable(st_r.enable);
  endproperty
  a_enable_keep: assert property (p_enable_keep)
    else $error("enable changed without a write");
  property p_freeze;
    @(posedge core_clk_i) disable iff (!nrst_i)
    !ce_i |=> ($stable(st_r) && $stable(flag));
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");
  property p_wait_ce;
    @(posedge core_clk_i) disable iff (!nrst_i)
    !ce_i |-> avs_waitrequest_o;
  endproperty
  a_wait_ce: assert property (p_wait_ce)
    else $error("answer shown while clock enable low");
  property p_ack_write;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (ce_i && st_r.bus == HLIE_IDLE && avs_write_i) |=>
      !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_ack_write: assert property (p_ack_write)
    else $error("write not answered in one wait cycle");
  property p_rdata_keep;
    @(posedge core_clk_i) disable iff (!nrst_i)
    !(ce_i && st_r.bus == HLIE_IDLE && (avs_read_i || avs_write_i)) |=>
      $stable(avs_readdata_o);
  endproperty
  a_rdata_keep: assert property (p_rdata_keep)
    else $error("read data changed without a request");
  property p_mask_rsvd;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (st_r.mask[7] == 1'b0) && (st_r.mask[2:0] == 3'h0);
  endproperty
  a_mask_rsvd: assert property (p_mask_rsvd)
    else $error("reserved mask bit set");
endmodule

/* tb/testbench.sv */
// Purpose: Self-checking bench for the link IRQ enable block
// Assumes: One wait cycle per access, event flags land in 3 edges
// Notes: Clock enable and byte lanes idle at run and all lanes
`timescale 1ns/100ps
`include "hlie_regs.svh"
module testbench;
  import hlie_pkg::*;
  logic core_clk_i;
  logic nrst_i;
  logic [`HLIE_ADDR_W-1:0] adr;
  logic rd_r;
  logic wr_r;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wait_o;
  logic [3:0] ev;
  logic irq_o;
  logic ce;
  logic [3:0] be;
  int miscompares;
  int cmp_count;
  hlie_top dut
  (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce),
    .avs_address_i(adr),
    .avs_read_i(rd_r),
    .avs_write_i(wr_r),
    .avs_writedata_i(wdata),
    .avs_byteenable_i(be),
    .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_o),
    .tx_begin_event_i(ev[3]),
    .rx_begin_event_i(ev[2]),
    .tx_finish_event_i(ev[1]),
    .rx_finish_event_i(ev[0]),
    .irq_o(irq_o)
  );
  // ****************************************
  // Clock, reset and watchdog
  // ****************************************
  initial
  begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  initial
  begin
    #(25 * 5000);
    miscompares++;
    give_verdict();
  end
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic give_verdict();
    if (miscompares == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask
  // Holds the request until the edge that samples waitrequest low
  task automatic access(input logic w, input logic [3:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    adr <= a;
    wdata <= d;
    rd_r <= ~w;
    wr_r <= w;
    do
    begin
      @(posedge core_clk_i);
      n++;
      if (n > 50)
      begin
        miscompares++;
        give_verdict();
      end
    end
    while (wait_o !== 1'b0);
    q = rdata;
    rd_r <= 1'b0;
    wr_r <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    access(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    access(1'b0, a, 32'h0, q);
    cmp_word(q, e);
  endtask
  // Rising edge on one event line, then settle past the synchroniser
  task automatic fire(input int i);
    ev[i] <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    ev[i] <= 1'b0;
    repeat (5) @(posedge core_clk_i);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic reset_values();
    rd_chk(`HLIE_OFF_ENABLE, 32'h0);
    rd_chk(`HLIE_OFF_STATUS, 32'h0);
    rd_chk(`HLIE_OFF_MASK, 32'h78);
    wr(`HLIE_OFF_ENABLE, 32'hFF);
    rd_chk(`HLIE_OFF_ENABLE, 32'h78);
    cmp_bit(irq_o, 1'b0);
  endtask
  task automatic one_event(input int i);
    logic [31:0] b;
    logic [31:0] o;
    b = 32'h1 << (i + 3);
    o = 32'h1 << (((i + 1) % 4) + 3);
    wr(`HLIE_OFF_ENABLE, b);
    fire((i + 1) % 4);
    cmp_bit(irq_o, 1'b0);
    rd_chk(`HLIE_OFF_STATUS, o);
    fire(i);
    cmp_bit(irq_o, 1'b1);
    rd_chk(`HLIE_OFF_STATUS, b);
    cmp_bit(irq_o, 1'b0);
    rd_chk(`HLIE_OFF_STATUS, 32'h0);
    wr(`HLIE_OFF_ENABLE, 32'h0);
    fire(i);
    cmp_bit(irq_o, 1'b0);
    // Clearing another bit must leave this flag, set with enable off
    wr(`HLIE_OFF_STATUS, o);
    rd_chk(`HLIE_OFF_STATUS, b);
    fire(i);
    wr(`HLIE_OFF_STATUS, b);
    rd_chk(`HLIE_OFF_STATUS, 32'h0);
  endtask
  // Mask hides a pending flag; unmapped read gives the fill pattern
  task automatic mask_and_unmapped();
    wr(`HLIE_OFF_ENABLE, 32'h78);
    wr(`HLIE_OFF_MASK, 32'h0);
    fire(3);
    cmp_bit(irq_o, 1'b0);
    wr(`HLIE_OFF_MASK, 32'h78);
    cmp_bit(irq_o, 1'b1);
    rd_chk(`HLIE_OFF_STATUS, 32'h40);
    rd_chk(4'hF, `HLIE_UNMAPPED_DATA);
  endtask
  // Clock enable low freezes bus and events; lane 0 off drops a write
  task automatic freeze_and_lanes();
    logic [31:0] q;
    wr(`HLIE_OFF_ENABLE, 32'h78);
    ce <= 1'b0;
    adr <= `HLIE_OFF_STATUS;
    rd_r <= 1'b1;
    fire(2);
    cmp_bit(wait_o, 1'b1);
    cmp_bit(irq_o, 1'b0);
    ce <= 1'b1;
    access(1'b0, `HLIE_OFF_STATUS, 32'h0, q);
    cmp_word(q, 32'h0);
    be <= 4'hE;
    wr(`HLIE_OFF_ENABLE, 32'h0);
    be <= 4'hF;
    rd_chk(`HLIE_OFF_ENABLE, 32'h78);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    miscompares = 0;
    cmp_count = 0;
    nrst_i = 1'b0;
    adr = '0;
    rd_r = 1'b0;
    wr_r = 1'b0;
    wdata = '0;
    ev = '0;
    ce = 1'b1;
    be = 4'hF;
    repeat (16) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    reset_values();
    for (int i = 0; i < 4; i++)
      one_event(i);
    mask_and_unmapped();
    freeze_and_lanes();
    give_verdict();
  end
endmodule
